// [core/nio_defines.vh]
// Functional notes
// - Sixteen input slots, each holds function code.
// - Input slots 0-7 reset to fixed codes.
// - Input slots 8-15 reset to fixed codes.
// - Sixteen output slots select internal status bits or command bits.
// - Output slots 0-7 reset to fixed codes.
// - Output slots 8-15 reset to fixed codes.
// - New codes apply only after configuration execute.
// - Old hardware rejects input codes 24-26.
// - Alarm status bit is on when normal.
// - Stop input has four selectable actions.
`ifndef NIO_DEFINES_VH
`define NIO_DEFINES_VH
`define NIO_ADDR_CMD      8'h00
`define NIO_ADDR_STAT     8'h04
`define NIO_ADDR_CTRL     8'h08
`define NIO_ADDR_FUNC     8'h0c
`define NIO_ADDR_EVT      8'h10
`define NIO_ADDR_MASK     8'h14
`define NIO_ADDR_INSEL    8'h40
`define NIO_ADDR_OUTSEL   8'h80
`define NIO_CTRL_EXEC     0
`define NIO_CTRL_OLDHW    1
`define NIO_CTRL_STOP_LO  2
`define NIO_CTRL_STOP_HI  3
`define NIO_EVT_REJECT    0
`define NIO_EVT_APPLIED   1
`define NIO_EVT_ALARM     2
`define NIO_IN_ALM_CLR    7'h18
`define NIO_IN_POS_PRESET 7'h19
`define NIO_IN_POS_CLR    7'h1a
`define NIO_OUT_ALARM     7'h41
`define NIO_OUT_WARNING   7'h42
`define NIO_OUT_READY     7'h43
`define NIO_OUT_MOVE      7'h44
`define NIO_OUT_END       7'h45
`define NIO_OUT_HOME_P    7'h46
`define NIO_OUT_TORQUE    7'h47
`define NIO_OUT_STEP      7'h48
`define NIO_OUT_ZONE1     7'h49
`define NIO_OUT_ZONE2     7'h4a
`define NIO_OUT_ZONE3     7'h4b
`define NIO_OUT_BUSY      7'h50
`define NIO_OUT_LIMP      7'h3c
`define NIO_OUT_SLIT      7'h3f
`define NIO_IN_DEFAULTS   128'h02_01_07_06_05_0a_09_08_00_10_12_03_04_32_31_30
`define NIO_OUT_DEFAULTS  128'h47_45_44_48_4b_4a_49_50_41_42_43_46_04_32_31_30
`define NIO_REGION_IN     2'h1
`define NIO_REGION_OUT    2'h2
`define NIO_RESP_OKAY     2'h0
`define NIO_RESP_SLVERR   2'h2
`define NIO_STAT_ALARM    1
`define NIO_STOP_IMMED    2'h0
`define NIO_STOP_DECEL    2'h1
`define NIO_STOP_IMMED_OFF 2'h2
`define NIO_STOP_DECEL_OFF 2'h3
`endif

// [core/nio_function_map.v]
`include "nio_defines.vh"
module nio_function_map
(
   // Clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite slave
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Internal motion status, from other clock domains of the drive
   input  wire [63:0] status_in,
   // Decoded internal commands, indexed by input function code
   output reg  [63:0] function_cmd,
   output reg  [1:0]  stop_action,
   output reg         irq
);
   reg  [6:0]  next_in_code [0:15];
   reg  [6:0]  in_code      [0:15];
   reg  [6:0]  next_out_code[0:15];
   reg  [6:0]  out_code     [0:15];
   reg  [15:0] cmd_bits;
   reg  [15:0] stat_bits;
   reg         old_hw;
   reg  [2:0]  evt;
   reg  [2:0]  mask;
   reg  [63:0] stat_s1;
   reg  [63:0] stat_s2;
   reg  [63:0] stat_s3;
   wire        alarm_rise;
   reg         have_aw;
   reg         have_w;
   reg  [7:0]  aw_addr;
   reg  [31:0] w_data;
   reg  [3:0]  w_strb;
   reg         exec_pulse;
   reg         reject_pulse;
   reg         evt_rd_clr;
   reg  [63:0] next_cmd;
   reg  [15:0] next_stat;
   reg  [2:0]  next_evt;
   reg  [31:0] next_rdata;
   reg  [1:0]  next_rresp;
   integer     i;
   integer     j;

   function valid_in_code;
      input [6:0] c;
      input       old;
      begin
         valid_in_code = (c <= 7'h12 && c != 7'h0e && c != 7'h0f) ||
                         (c >= `NIO_IN_ALM_CLR && c <= 7'h1b && !(old && c <= `NIO_IN_POS_CLR)) ||
                         (c >= 7'h20 && c <= 7'h35);
      end
   endfunction

   function valid_out_code;
      input [6:0] c;
      begin
         valid_out_code = (c <= 7'h12 && c != 7'h0e && c != 7'h0f) ||
                          (c >= 7'h20 && c <= 7'h35) ||
                          (c >= `NIO_OUT_LIMP && c <= `NIO_OUT_SLIT) ||
                          (c >= `NIO_OUT_ALARM && c <= `NIO_OUT_ZONE3) || c == `NIO_OUT_BUSY;
      end
   endfunction

   // Reset code of one slot, taken from a table of byte-wide entries.
   function [6:0] slot_default;
      input [127:0] tbl;
      input [3:0]   n;
      begin
         slot_default = tbl[8 * n +: 7];
      end
   endfunction

   // The address selects one word of the input slot region.
   function is_in_slot;
      input [7:0] a;
      begin
         is_in_slot = (a[7:6] == `NIO_REGION_IN) && (a[1:0] == 2'h0);
      end
   endfunction

   // The address selects one word of the output slot region.
   function is_out_slot;
      input [7:0] a;
      begin
         is_out_slot = (a[7:6] == `NIO_REGION_OUT) && (a[1:0] == 2'h0);
      end
   endfunction

   // Status source of one output code; code 0 gives zero, codes up to 35h read command bits, higher codes read status bits.
   function out_value;
      input [6:0]  c;
      input [63:0] cmd;
      input [63:0] st;
      begin
         if (c == 7'h00)
            out_value = 1'b0;
         else if (c <= 7'h35)
            out_value = cmd[c[5:0]];
         else if (c == `NIO_OUT_ALARM)
            out_value = ~st[c[5:0]];
         else if (c == `NIO_OUT_BUSY)
            out_value = st[6'h3d];
         else
            out_value = st[c[5:0]];
      end
   endfunction

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         stat_s1 <= 64'h0;
         stat_s2 <= 64'h0;
         stat_s3 <= 64'h0;
      end
      else
      begin
         stat_s1 <= status_in;
         stat_s2 <= stat_s1;
         stat_s3 <= stat_s2;
      end
   end

   // Edge detection works on synchronised copies only, never on the first stage.
   assign alarm_rise = stat_s2[`NIO_STAT_ALARM] && !stat_s3[`NIO_STAT_ALARM];

   // Decode command bits through the active mapping.
   always @*
   begin
      next_cmd = 64'h0;
      for (j = 0; j < 16; j = j + 1)
         if (in_code[j] != 7'h00)
            next_cmd[in_code[j][5:0]] = next_cmd[in_code[j][5:0]] | cmd_bits[j];
      next_stat = 16'h0;
      for (j = 0; j < 16; j = j + 1)
         next_stat[j] = out_value(out_code[j], function_cmd, stat_s2);
   end

   // Event flags; an event in the same cycle as the read clear is kept.
   always @*
   begin
      next_evt = evt;
      if (evt_rd_clr)
         next_evt = 3'h0;
      if (reject_pulse)
         next_evt[`NIO_EVT_REJECT] = 1'b1;
      if (exec_pulse)
         next_evt[`NIO_EVT_APPLIED] = 1'b1;
      if (alarm_rise)
         next_evt[`NIO_EVT_ALARM] = 1'b1;
   end

   // Read data for the address on the read address channel.
   always @*
   begin
      next_rdata = 32'h0;
      next_rresp = `NIO_RESP_OKAY;
      if (s_axi_araddr == `NIO_ADDR_CMD)
         next_rdata = {16'h0, cmd_bits};
      else if (s_axi_araddr == `NIO_ADDR_STAT)
         next_rdata = {16'h0, stat_bits};
      else if (s_axi_araddr == `NIO_ADDR_CTRL)
         next_rdata = {28'h0, stop_action, old_hw, 1'b0};
      else if (s_axi_araddr == `NIO_ADDR_FUNC)
         next_rdata = function_cmd[31:0];
      else if (s_axi_araddr == `NIO_ADDR_EVT)
         next_rdata = {29'h0, evt};
      else if (s_axi_araddr == `NIO_ADDR_MASK)
         next_rdata = {29'h0, mask};
      else if (is_in_slot(s_axi_araddr))
         next_rdata = {9'h0, in_code[s_axi_araddr[5:2]], 9'h0, next_in_code[s_axi_araddr[5:2]]};
      else if (is_out_slot(s_axi_araddr))
         next_rdata = {9'h0, out_code[s_axi_araddr[5:2]], 9'h0, next_out_code[s_axi_araddr[5:2]]};
      else
         next_rresp = `NIO_RESP_SLVERR;
   end

   // Registered views of the mapping and of the event flags.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         function_cmd <= 64'h0;
         stat_bits    <= 16'h0;
         evt          <= 3'h0;
         irq          <= 1'b0;
      end
      else
      begin
         function_cmd <= next_cmd;
         stat_bits    <= next_stat;
         evt          <= next_evt;
         irq          <= |(next_evt & mask);
      end
   end

   // Bus channels and the configuration registers.

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= 2'h0;
         s_axi_rdata   <= 32'h0;
         have_aw       <= 1'b0;
         have_w        <= 1'b0;
         aw_addr       <= 8'h0;
         w_data        <= 32'h0;
         w_strb        <= 4'h0;
         cmd_bits      <= 16'h0;
         old_hw        <= 1'b0;
         stop_action   <= `NIO_STOP_IMMED;
         mask          <= 3'h0;
         exec_pulse    <= 1'b0;
         reject_pulse  <= 1'b0;
         evt_rd_clr    <= 1'b0;
         // Pending and active codes both start from the default mapping.
         for (i = 0; i < 16; i = i + 1)
         begin
            in_code[i]       <= slot_default(`NIO_IN_DEFAULTS, i[3:0]);
            next_in_code[i]  <= slot_default(`NIO_IN_DEFAULTS, i[3:0]);
            out_code[i]      <= slot_default(`NIO_OUT_DEFAULTS, i[3:0]);
            next_out_code[i] <= slot_default(`NIO_OUT_DEFAULTS, i[3:0]);
         end
      end
      else
      begin
         exec_pulse    <= 1'b0;
         reject_pulse  <= 1'b0;
         evt_rd_clr    <= 1'b0;
         // Each ready is a single-cycle pulse, so one item is taken per offer.
         s_axi_awready <= !have_aw && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !have_w && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            have_aw <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            have_w <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (have_aw && have_w && !s_axi_bvalid)
         begin
            have_aw      <= 1'b0;
            have_w       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= 2'h0;
            if (aw_addr == `NIO_ADDR_CMD)
            begin
               if (w_strb[0]) cmd_bits[7:0]  <= w_data[7:0];
               if (w_strb[1]) cmd_bits[15:8] <= w_data[15:8];
            end
            else if (aw_addr == `NIO_ADDR_CTRL && w_strb[0])
            begin
               exec_pulse  <= w_data[`NIO_CTRL_EXEC];
               old_hw      <= w_data[`NIO_CTRL_OLDHW];
               stop_action <= w_data[`NIO_CTRL_STOP_HI:`NIO_CTRL_STOP_LO];
               if (w_data[`NIO_CTRL_EXEC])
                  for (i = 0; i < 16; i = i + 1)
                  begin
                     in_code[i]  <= next_in_code[i];
                     out_code[i] <= next_out_code[i];
                  end
            end
            else if (aw_addr == `NIO_ADDR_MASK && w_strb[0])
               mask <= w_data[2:0];
            else if (is_in_slot(aw_addr) && w_strb[0])
            begin
               if (valid_in_code(w_data[6:0], old_hw) && w_data[31:7] == 25'h0)
                  next_in_code[aw_addr[5:2]] <= w_data[6:0];
               else
               begin
                  reject_pulse <= 1'b1;
                  s_axi_bresp  <= 2'h2;
               end
            end
            else if (is_out_slot(aw_addr) && w_strb[0])
            begin
               if (valid_out_code(w_data[6:0]) && w_data[31:7] == 25'h0)
                  next_out_code[aw_addr[5:2]] <= w_data[6:0];
               else
               begin
                  reject_pulse <= 1'b1;
                  s_axi_bresp  <= 2'h2;
               end
            end
            else if (aw_addr != `NIO_ADDR_STAT && aw_addr != `NIO_ADDR_FUNC && aw_addr != `NIO_ADDR_EVT)
               s_axi_bresp <= 2'h2;
         end
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            // Reading the event register clears it one cycle later.
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= next_rresp;
            s_axi_rdata  <= next_rdata;
            evt_rd_clr   <= (s_axi_araddr == `NIO_ADDR_EVT);
         end
         if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// [sim/network_io_function_map_test.sv]
module network_io_function_map_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        aclk, aresetn, alarm, busy, irq;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, stop_action, r;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [63:0] status_in, function_cmd;
   int          error_cnt = 0;
   int          n_checks = 0;
   byte         in_def[16] = '{48, 49, 50, 4, 3, 18, 16, 0, 8, 9, 10, 5, 6, 7, 1, 2};
   byte         out_def[16] = '{48, 49, 50, 4, 70, 67, 66, 65, 80, 73, 74, 75, 72, 68, 69, 71};
   nio_function_map u_nio_function_map (.*);
   nio_motion_status u_nio_motion_status (.*);
   initial
   begin
      aclk = 0;
      forever #25 aclk = ~aclk;
   end
   initial
   begin
      s_axi_awvalid = 0;
      s_axi_wvalid = 0;
      s_axi_bready = 0;
      s_axi_arvalid = 0;
      s_axi_rready = 0;
      alarm = 0;
      busy = 0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'h0;
   end
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic wrap_up;
      if (error_cnt == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      repeat (64)
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 0;
         if (s_axi_wready)
            s_axi_wvalid <= 0;
         if (s_axi_bvalid)
         begin
            r = s_axi_bresp;
            s_axi_bready <= 0;
            return;
         end
      end
      error_cnt++;
      wrap_up;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      repeat (64)
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 0;
         if (s_axi_rvalid)
         begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 0;
            return;
         end
      end
      error_cnt++;
      wrap_up;
   endtask
   task automatic t_defaults;
      for (int i = 0; i < 16; i++)
      begin
         rd(8'h40 + 8'(4 * i));
         chk("in slot", {9'h0, in_def[i][6:0], 9'h0, in_def[i][6:0]}, d);
         rd(8'h80 + 8'(4 * i));
         chk("out slot", {9'h0, out_def[i][6:0], 9'h0, out_def[i][6:0]}, d);
      end
   endtask
   task automatic t_apply;
      wr(8'h5c, 32'h11);
      wr(8'h80, 32'h11);
      rd(8'h5c);
      chk("pending", 32'h11, d);
      wr(8'h08, 32'h1);
      rd(8'h5c);
      chk("applied", 32'h110011, d);
      wr(8'h00, 32'h80);
      repeat (5) @(posedge aclk);
      chk("cmd", 1, function_cmd[17]);
      rd(8'h04);
      chk("echo", 1, d[0]);
   endtask
   task automatic t_alarm;
      rd(8'h04);
      chk("normal", 32'h80, d & 32'h180);
      alarm <= 1;
      busy <= 1;
      repeat (5) @(posedge aclk);
      rd(8'h04);
      chk("alarm", 32'h100, d & 32'h180);
   endtask
   task automatic t_reject;
      wr(8'h14, 32'h1);
      wr(8'h08, 32'h2);
      for (int c = 24; c < 27; c++)
      begin
         wr(8'h40, 32'(c));
         chk("reject", 2, r);
      end
      chk("irq", 1, irq);
      rd(8'h10);
      chk("evt", 32'h7, d);
      repeat (2) @(posedge aclk);
      chk("irq clr", 0, irq);
      rd(8'h40);
      chk("kept", 32'h300030, d);
      wr(8'h40, 32'h1e);
      chk("bad code", 2, r);
      rd(8'h30);
      chk("unmapped", 2, r);
   endtask
   task automatic t_stop;
      for (int s = 0; s < 4; s++)
      begin
         wr(8'h08, 32'(s << 2));
         repeat (2) @(posedge aclk);
         chk("stop", 32'(s), stop_action);
      end
      wr(8'h44, 32'h18);
      chk("new hw", 0, r);
   endtask
   initial
   begin
      aresetn = 0;
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      t_defaults;
      t_apply;
      t_alarm;
      t_reject;
      t_stop;
      wrap_up;
   end
endmodule

// [sim/nio_map_properties.sv]
module nio_map_properties
(
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Bus handshakes
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic [31:0] s_axi_rdata,
   // Stop action
   input wire logic [1:0]  stop_action
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
   a_w_pulse: assert property (s_axi_wready |=> !s_axi_wready) else $error("wready held");
   a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready) else $error("arready held");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
   a_resp_legal: assert property (s_axi_bvalid || s_axi_rvalid |-> !s_axi_bresp[0] && !s_axi_rresp[0])
      else $error("bad response code");
   a_stop_quiet: assert property ($changed(stop_action) |-> ##[0:2] s_axi_bvalid)
      else $error("stop action moved alone");
   c_wr: cover property (s_axi_bvalid && s_axi_bready);
   c_rd: cover property (s_axi_rvalid && s_axi_rready);
   c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind nio_function_map nio_map_properties u_nio_map_properties (.*);

// [sim/nio_motion_status.sv]
module nio_motion_status
(
   // Clock
   input  wire logic        aclk,
   // Conditions raised by the bench
   input  wire logic        alarm,
   input  wire logic        busy,
   // Internal status toward the block
   output logic [63:0] status_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // Alarm present sits on bit 1, internal busy on bit 61.
   always @(posedge aclk)
      status_in <= {2'h0, busy, 59'h0, alarm, 1'b0};
endmodule
